// ### common/rcg_map.svh
`ifndef RCG_MAP_SVH
`define RCG_MAP_SVH
// avalon word addresses (byte address / 4)
`define RCG_ADDR_CTRL 4'h0
`define RCG_ADDR_TERM 4'h1
`define RCG_ADDR_QSTOP 4'h2
`define RCG_ADDR_ACC_DW 4'h3
`define RCG_ADDR_DEC_DW 4'h4
`define RCG_ADDR_RAMP 4'h5
`define RCG_ADDR_STATUS 4'h6
`define RCG_ADDR_FREQ 4'h7
// ctrl field positions
`define RCG_CTRL_LATCH_BIT 0
`define RCG_CTRL_GATE_BIT 1
`define RCG_CTRL_STOPPOL_LSB 2
`define RCG_CTRL_METHOD_LSB 4
`define RCG_CTRL_BRAKE_BIT 6
// terminal function codes
`define RCG_FN_RUN_EN 6'h0D
`define RCG_FN_LATCH 6'h0E
// reset values: frequency in 0.01 Hz, times in 0.1 s
`define RCG_RST_QSTOP 16'h0032
`define RCG_RST_DW_FREQ 16'h01F4
`define RCG_RST_DW_TIME 16'h0000
`define RCG_RST_TERM 24'h0000_00
`define RCG_RST_RAMP 16'h0001
// timing: 25 MHz clock, 0.1 s tick, 1 ms pulse minimum
`define RCG_CLK_HZ 25000000
`define RCG_TENTH_S_NS 100000000
`define RCG_TICK_CYC (`RCG_CLK_HZ / 10)
`define RCG_MIN_PULSE_NS 1000000
`define RCG_MIN_PULSE_CYC ((`RCG_MIN_PULSE_NS / 40))
// limits in 0.1 s
`define RCG_QSTOP_MAX 16'h1770
`define RCG_ACC_DW_MAX 16'h0064
`define RCG_DEC_DW_MAX 16'h0258
`endif

// ### common/rcg_pkg.sv
`default_nettype none
package rcg_pkg;
  // stop behaviour when run-enable drops
  typedef enum logic [1:0] {
    RCG_STOP_COAST = 2'b00,
    RCG_STOP_RSVD = 2'b01,
    RCG_STOP_QSTOP = 2'b10,
    RCG_STOP_QRESUME = 2'b11
  } rcg_stop_pol_t;
  // sequencer states
  typedef enum logic [2:0] {
    RCG_ST_IDLE = 3'b000,
    RCG_ST_ACC = 3'b001,
    RCG_ST_ACC_DW = 3'b010,
    RCG_ST_RUN = 3'b011,
    RCG_ST_DEC = 3'b100,
    RCG_ST_DEC_DW = 3'b101,
    RCG_ST_QSTOP = 3'b110
  } rcg_state_t;
  // dwell setting pair
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] time_ds;
  } rcg_dwell_t;
  // cleaned terminal commands
  typedef struct packed {
    logic fwd;
    logic rev;
    logic run_en;
    logic latch_stop;
  } rcg_cmd_t;
endpackage
`default_nettype wire

// ### core/rcg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-flop synchroniser with agreement filter per input bit
module rcg_sync #(
  parameter int W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1; // first stage, read only by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // shift chain; reset clears all stages
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else if (ce)
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // output follows only when stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dout <= '0;
    else if (ce)
      dout <= (s2 & s3) | (dout & (s2 | s3));
  end
endmodule // rcg_sync
`default_nettype wire

// ### core/rcg_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcg_map.svh"
// 0.1 s time base; the count is long so it is a parameter
module rcg_tick #(
  parameter int TICK_CYC = `RCG_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);
  logic [22:0] cnt; // cycles within one tenth second
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (cnt == 23'(TICK_CYC - 1));
      if (cnt == 23'(TICK_CYC - 1))
        cnt <= '0;
      else
        cnt <= cnt + 23'h0000_01;
    end
  end
endmodule // rcg_tick
`default_nettype wire

// ### core/rcg_run_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcg_map.svh"
module rcg_run_gate #(
  parameter int TICK_CYC = `RCG_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [6:0] multifunction_inputs,
  input wire logic fwd_in,
  input wire logic rev_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] out_freq,
  output logic out_enable,
  output logic out_reverse
);
  // config registers
  logic [6:0] ctrl; // latch, gate, stop policy, method, brake
  logic [23:0] terminal_function_select; // 6-bit code per terminal 0..3
  logic [15:0] qstop_time;
  rcg_pkg::rcg_dwell_t acc_dw;
  rcg_pkg::rcg_dwell_t dec_dw;
  logic [15:0] ramp_step; // freq change per tenth second
  logic [15:0] target_freq;
  // live state
  rcg_pkg::rcg_state_t state;
  logic run_latch; // command held in latch mode
  logic run_dir; // 1 = reverse
  logic acc_dw_done; // first-acceleration dwell already spent
  logic [15:0] dw_cnt; // dwell tenths elapsed
  logic [15:0] q_step; // quick-stop decrement per tick
  logic restart_block; // policy 2 needs a fresh command
  logic ack; // one-cycle bus answer
  logic tick;
  logic [8:0] sync_out;
  rcg_pkg::rcg_cmd_t cmd;
  logic run_cmd;
  logic enable_ok;
  logic [1:0] btn_prev; // last fwd/rev levels, for fresh-press edges
  logic new_cmd;
  // helper: does any terminal carry the given function
  function automatic logic term_has(input logic [5:0] code,
    input logic [23:0] sel, input logic [6:0] pins);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++)
      if (sel[i*6 +: 6] == code && pins[i])
        hit = 1'b1;
    return hit;
  endfunction
  // helper: dwell usable only when both fields are nonzero
  function automatic logic dw_on(input rcg_pkg::rcg_dwell_t d,
    input logic vf);
    return vf && (d.freq != 16'h0000) && (d.time_ds != 16'h0000);
  endfunction
  // all pin inputs cross in through the filter; pulses exceed 3 clocks
  rcg_sync #(.W(9)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din({multifunction_inputs, fwd_in, rev_in}),
    .dout(sync_out)
  );
  rcg_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .tick(tick)
  );
  // decode the terminals through the function table
  always_comb
  begin
    cmd.fwd = sync_out[1];
    cmd.rev = sync_out[0];
    cmd.run_en = term_has(`RCG_FN_RUN_EN, terminal_function_select,
      sync_out[8:2]);
    cmd.latch_stop = term_has(`RCG_FN_LATCH, terminal_function_select,
      sync_out[8:2]);
  end
  // gate: policy 0 always, policy 1 needs the run-enable terminal
  assign enable_ok = !ctrl[`RCG_CTRL_GATE_BIT] || cmd.run_en;
  assign new_cmd = |({cmd.fwd, cmd.rev} & ~btn_prev);
  assign run_cmd = ctrl[`RCG_CTRL_LATCH_BIT] ? run_latch
                 : (cmd.fwd ^ cmd.rev);
  // edge memory of fwd/rev; reset to the idle level so no false press
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      btn_prev <= 2'b00;
    else if (ce)
      btn_prev <= {cmd.fwd, cmd.rev};
  end
  // three-wire latch; a lone press sets, both or stop clears
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      run_latch <= 1'b0;
      run_dir <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd.fwd && cmd.rev)
        run_latch <= 1'b0;
      else if (ctrl[`RCG_CTRL_LATCH_BIT] && !cmd.latch_stop)
        run_latch <= 1'b0;
      else if (cmd.fwd || cmd.rev)
      begin
        run_latch <= 1'b1;
        run_dir <= cmd.rev;
      end
    end
  end
  // policy 2 block: set while a quick stop runs, cleared by a new press
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      restart_block <= 1'b0;
    else if (ce)
    begin
      if (state == rcg_pkg::RCG_ST_QSTOP &&
          ctrl[`RCG_CTRL_STOPPOL_LSB +: 2] == rcg_pkg::RCG_STOP_QSTOP)
        restart_block <= 1'b1;
      else if (new_cmd)
        restart_block <= 1'b0;
    end
  end
  // quick-stop step: present frequency divided by qstop_time, plus one, recomputed every tick;
  // a zero time empties the output within one tick
  assign q_step = (qstop_time == 16'h0000) ? 16'hFFFF
                : (out_freq / qstop_time) + 16'h0001;
  // main ramp and dwell sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= rcg_pkg::RCG_ST_IDLE;
      out_freq <= 16'h0000;
      dw_cnt <= 16'h0000;
      acc_dw_done <= 1'b0;
    end
    else if (ce)
    begin
      if (!enable_ok && state != rcg_pkg::RCG_ST_IDLE &&
          ctrl[`RCG_CTRL_STOPPOL_LSB +: 2] == rcg_pkg::RCG_STOP_COAST)
      begin
        state <= rcg_pkg::RCG_ST_IDLE;
        out_freq <= 16'h0000;
        acc_dw_done <= 1'b0;
      end
      else if (!enable_ok && state != rcg_pkg::RCG_ST_IDLE &&
               state != rcg_pkg::RCG_ST_QSTOP)
        state <= rcg_pkg::RCG_ST_QSTOP;
      else
        case (state)
          rcg_pkg::RCG_ST_IDLE:
          begin
            acc_dw_done <= 1'b0;
            dw_cnt <= 16'h0000;
            if (run_cmd && enable_ok && !restart_block)
              state <= rcg_pkg::RCG_ST_ACC;
          end
          rcg_pkg::RCG_ST_ACC:
          begin
            if (!run_cmd)
              state <= rcg_pkg::RCG_ST_DEC;
            else if (!acc_dw_done &&
                     dw_on(acc_dw, ctrl[`RCG_CTRL_METHOD_LSB +: 2] == 2'b00) &&
                     out_freq >= acc_dw.freq)
            begin
              state <= rcg_pkg::RCG_ST_ACC_DW;
              out_freq <= acc_dw.freq;
              dw_cnt <= 16'h0000;
            end
            else if (out_freq >= target_freq)
            begin
              out_freq <= target_freq;
              state <= rcg_pkg::RCG_ST_RUN;
            end
            else if (tick)
              out_freq <= (target_freq - out_freq > ramp_step) ?
                out_freq + ramp_step : target_freq;
          end
          rcg_pkg::RCG_ST_ACC_DW:
          begin
            acc_dw_done <= 1'b1;
            if (!run_cmd)
              state <= rcg_pkg::RCG_ST_DEC;
            else if (dw_cnt >= acc_dw.time_ds)
              state <= rcg_pkg::RCG_ST_ACC;
            else if (tick)
              dw_cnt <= dw_cnt + 16'h0001;
          end
          rcg_pkg::RCG_ST_RUN:
          begin
            acc_dw_done <= 1'b1;
            if (!run_cmd)
              state <= rcg_pkg::RCG_ST_DEC;
            else if (out_freq != target_freq)
              state <= rcg_pkg::RCG_ST_ACC; // reference change, no dwell
          end
          rcg_pkg::RCG_ST_DEC:
          begin
            acc_dw_done <= 1'b1;
            if (run_cmd)
              state <= rcg_pkg::RCG_ST_ACC;
            else if (!ctrl[`RCG_CTRL_BRAKE_BIT] &&
                     dw_on(dec_dw, ctrl[`RCG_CTRL_METHOD_LSB +: 2] == 2'b00) &&
                     out_freq > dec_dw.freq &&
                     out_freq - dec_dw.freq <= ramp_step && tick)
            begin
              state <= rcg_pkg::RCG_ST_DEC_DW;
              out_freq <= dec_dw.freq;
              dw_cnt <= 16'h0000;
            end
            else if (out_freq == 16'h0000)
              state <= rcg_pkg::RCG_ST_IDLE;
            else if (tick)
              out_freq <= (out_freq > ramp_step) ? out_freq - ramp_step
                : 16'h0000;
          end
          rcg_pkg::RCG_ST_DEC_DW:
          begin
            if (run_cmd)
              state <= rcg_pkg::RCG_ST_ACC;
            else if (dw_cnt >= dec_dw.time_ds)
              state <= rcg_pkg::RCG_ST_DEC;
            else if (tick)
              dw_cnt <= dw_cnt + 16'h0001;
          end
          rcg_pkg::RCG_ST_QSTOP:
          begin
            if (out_freq == 16'h0000)
              state <= rcg_pkg::RCG_ST_IDLE;
            else if (tick)
              out_freq <= (out_freq > q_step) ? out_freq - q_step
                : 16'h0000;
          end
          default:
            state <= rcg_pkg::RCG_ST_IDLE;
        endcase
    end
  end
  assign out_enable = (state != rcg_pkg::RCG_ST_IDLE);
  assign out_reverse = ctrl[`RCG_CTRL_LATCH_BIT] ? run_dir : cmd.rev;
  // register writes; quick-stop and dwell times saturate at their range
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl <= 7'h00;
      terminal_function_select <= `RCG_RST_TERM;
      qstop_time <= `RCG_RST_QSTOP;
      acc_dw <= {`RCG_RST_DW_FREQ, `RCG_RST_DW_TIME};
      dec_dw <= {`RCG_RST_DW_FREQ, `RCG_RST_DW_TIME};
      ramp_step <= `RCG_RST_RAMP;
      target_freq <= 16'h0000;
    end
    else if (ce && avs_write && ack) // lands as waitrequest goes low
      case (avs_address)
        `RCG_ADDR_CTRL: ctrl <= avs_writedata[6:0];
        `RCG_ADDR_TERM: terminal_function_select <= avs_writedata[23:0];
        `RCG_ADDR_QSTOP:
          qstop_time <= (avs_writedata[15:0] > `RCG_QSTOP_MAX) ?
            `RCG_QSTOP_MAX : avs_writedata[15:0];
        `RCG_ADDR_ACC_DW:
          acc_dw <= {avs_writedata[31:16],
            (avs_writedata[15:0] > `RCG_ACC_DW_MAX) ?
            `RCG_ACC_DW_MAX : avs_writedata[15:0]};
        `RCG_ADDR_DEC_DW:
          dec_dw <= {avs_writedata[31:16],
            (avs_writedata[15:0] > `RCG_DEC_DW_MAX) ?
            `RCG_DEC_DW_MAX : avs_writedata[15:0]};
        `RCG_ADDR_RAMP: {target_freq, ramp_step} <= avs_writedata;
        default: ;
      endcase
  end
  // every access takes exactly one wait cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ack <= 1'b0;
    else if (ce)
      ack <= (avs_read || avs_write) && !ack;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  // read data registered; unmapped reads zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (ce && avs_read && !ack)
      case (avs_address)
        `RCG_ADDR_CTRL: avs_readdata <= {25'h000_0000, ctrl};
        `RCG_ADDR_TERM: avs_readdata <= {8'h00, terminal_function_select};
        `RCG_ADDR_QSTOP: avs_readdata <= {16'h0000, qstop_time};
        `RCG_ADDR_ACC_DW: avs_readdata <= acc_dw;
        `RCG_ADDR_DEC_DW: avs_readdata <= dec_dw;
        `RCG_ADDR_RAMP: avs_readdata <= {target_freq, ramp_step};
        `RCG_ADDR_STATUS:
          avs_readdata <= {22'h00_0000, acc_dw_done, restart_block,
            run_latch, enable_ok, cmd.run_en, out_reverse, out_enable,
            state};
        `RCG_ADDR_FREQ: avs_readdata <= {16'h0000, out_freq};
        default: avs_readdata <= 32'h0000_0000;
      endcase
  end
endmodule // rcg_run_gate
`default_nettype wire

// ### sim/rcg_run_gate_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the run sequencer and its register port
module rcg_run_gate_chk #(
  parameter int TICK_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] out_freq,
  input wire logic out_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // reset must leave the output blocked, so no disable here
  AST_RESET_ZERO: assert property (disable iff (1'b0)
    rst |=> out_freq == 16'h0000 && !out_enable)
    else $error("outputs not cleared by reset");
  AST_WAIT_FIRST: assert property (
    (avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait on new request");
  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  AST_UNMAPPED: assert property (
    avs_read && !avs_waitrequest && avs_address[3]
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not 0");
  AST_READ_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(out_freq) && $stable(out_enable))
    else $error("state moved while frozen");
  AST_IDLE_ZERO: assert property (
    !out_enable && !$past(out_enable) |-> out_freq == 16'h0000)
    else $error("frequency while blocked");
  AST_FREQ_EN: assert property (
    out_freq != 16'h0000 |-> out_enable)
    else $error("frequency without enable");
  COV_START: cover property ($rose(out_enable));
  COV_STOP: cover property ($fell(out_enable));
  COV_UNMAP: cover property (avs_read && !avs_waitrequest && avs_address[3]);
endmodule // rcg_run_gate_chk
bind rcg_run_gate rcg_run_gate_chk #(.TICK_CYC(TICK_CYC)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .out_freq(out_freq), .out_enable(out_enable));
`default_nettype wire

// ### sim/rcg_panel.sv
`timescale 1ns/1ps
`default_nettype none
// buttons and switches; open contacts read low through pull-downs
module rcg_panel (
  input wire logic clk_sys,
  output logic [6:0] multifunction_inputs,
  output logic fwd_in,
  output logic rev_in
);
  initial
  begin
    multifunction_inputs = 7'h00;
    fwd_in = 1'b0;
    rev_in = 1'b0;
  end
  // set both buttons as levels, for held-switch operation
  task automatic set_btn(input logic f, input logic r);
    @(posedge clk_sys);
    fwd_in <= f;
    rev_in <= r;
  endtask
  // momentary push: held past 1 ms at 40 ns, then springs open
  task automatic press(input logic f, input logic r);
    set_btn(f, r);
    repeat (26000) @(posedge clk_sys);
    set_btn(1'b0, 1'b0);
  endtask
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_sys);
    multifunction_inputs[i] <= v;
  endtask
endmodule // rcg_panel
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, out_enable, out_reverse, fwd, rev, ok;
  logic [15:0] out_freq;
  logic [6:0] mfi;
  int error_cnt = 0;
  int tests_run = 0;
  int dw_cnt = 0;
  // short tick so ramps take tens of cycles
  rcg_run_gate #(.TICK_CYC(10)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .multifunction_inputs(mfi),
    .fwd_in(fwd), .rev_in(rev), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .out_freq(out_freq),
    .out_enable(out_enable), .out_reverse(out_reverse));
  rcg_panel pnl_u (.clk_sys(clk_sys), .multifunction_inputs(mfi),
    .fwd_in(fwd), .rev_in(rev));
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  // cycles spent holding at the 5 Hz dwell point
  always @(posedge clk_sys)
  begin
    if (out_enable === 1'b1 && out_freq === 16'h01F4)
      dw_cnt <= dw_cnt + 1;
  end
  // one avalon cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  // bounded wait for the output enable to reach a level
  task automatic wait_en(input logic v, input int lim);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++)
    begin
      @(posedge clk_sys);
      ok = (out_enable === v);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard, well above the one long button hold plus the ramps
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and the unmapped hole
    rd(4'h2); `CHK("qstop", 32'h0000_0032, q)
    rd(4'h3); `CHK("acc dwell", 32'h01F4_0000, q)
    rd(4'h4); `CHK("dec dwell", 32'h01F4_0000, q)
    rd(4'h1); `CHK("term", 32'h0000_0000, q)
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC); `CHK("unmapped", 32'h0000_0000, q)
    wr(4'h2, 32'h0000_1770);
    rd(4'h2); `CHK("qstop max", 32'h0000_1770, q)
    $display("test registers done");
    // latch mode: pin0 is the stop contact, kept closed to run
    wr(4'h2, 32'h0000_0002);
    wr(4'h1, 32'h0000_000E);
    wr(4'h5, 32'h03E8_0064);
    wr(4'h3, 32'h01F4_0003);
    wr(4'h0, 32'h0000_0001);
    pnl_u.set_pin(0, 1'b1);
    pnl_u.press(1'b1, 1'b0);
    `CHK("latched run", 1'b1, out_enable)
    `CHK("target", 16'h03E8, out_freq)
    `CHK("dwell span", 1'b1, dw_cnt >= 30 && dw_cnt <= 45)
    rd(4'h7); `CHK("freq reg", 32'h0000_03E8, q)
    pnl_u.set_pin(0, 1'b0);
    wait_en(1'b0, 400);
    `CHK("stop opens latch", 1'b1, ok)
    $display("test latch done");
    // gated, quick stop: return of the gate alone must not restart
    wr(4'h1, 32'h0000_0340);
    wr(4'h0, 32'h0000_000A);
    pnl_u.set_pin(1, 1'b1);
    pnl_u.set_btn(1'b1, 1'b0);
    wait_en(1'b1, 30000);
    `CHK("gated start", 1'b1, ok)
    // let the ramp leave zero so the quick stop has work to do
    repeat (30) @(posedge clk_sys);
    pnl_u.set_pin(1, 1'b0);
    repeat (8) @(posedge clk_sys);
    `CHK("decelerating", 1'b1, out_enable)
    wait_en(1'b0, 200);
    `CHK("quick stop", 1'b1, ok)
    pnl_u.set_pin(1, 1'b1);
    repeat (200) @(posedge clk_sys);
    `CHK("no restart", 1'b0, out_enable)
    $display("test quick stop done");
    // coast: a fresh command, a short freeze, then the gate drops
    wr(4'h0, 32'h0000_0002);
    pnl_u.set_btn(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    pnl_u.set_btn(1'b1, 1'b0);
    wait_en(1'b1, 30000);
    `CHK("coast start", 1'b1, ok)
    ce <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ce <= 1'b1;
    pnl_u.set_pin(1, 1'b0);
    wait_en(1'b0, 12);
    `CHK("coast", 1'b1, ok)
    `CHK("coast freq", 16'h0000, out_freq)
    $display("test coast done");
    // latch with resume policy: reverse press, gate cycles, both stop
    wr(4'h1, 32'h0000_034E);
    wr(4'h0, 32'h0000_000F);
    pnl_u.set_pin(0, 1'b1);
    pnl_u.set_btn(1'b0, 1'b1);
    pnl_u.set_pin(1, 1'b1);
    wait_en(1'b1, 100);
    `CHK("resume start", 1'b1, ok)
    `CHK("reverse", 1'b1, out_reverse)
    repeat (30) @(posedge clk_sys);
    pnl_u.set_pin(1, 1'b0);
    wait_en(1'b0, 200);
    `CHK("resume stop", 1'b1, ok)
    pnl_u.set_pin(1, 1'b1);
    wait_en(1'b1, 100);
    `CHK("resumed", 1'b1, ok)
    repeat (30) @(posedge clk_sys);
    pnl_u.set_btn(1'b1, 1'b1);
    wait_en(1'b0, 400);
    `CHK("both stop", 1'b1, ok)
    $display("test resume done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
